// >>> hw/fie_pkg.sv
// package: offsets, field positions, reset values and codes of the error handler
package fie_pkg;

  // ---------------------------------------------------------------
  // register byte offsets on the apb bus
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_PRIMARY_STATUS = 8'h00;
  localparam logic [7:0] OFF_SECONDARY_STATUS = 8'h04;
  localparam logic [7:0] OFF_INTERNAL_ERROR = 8'h08;
  localparam logic [7:0] OFF_INT_MASK = 8'h0c;
  localparam logic [7:0] OFF_CONTROL = 8'h10;
  localparam logic [7:0] OFF_RING_STATE = 8'h14;
  localparam logic [7:0] OFF_FUNCTION_CONTROL = 8'h18;
  localparam logic [7:0] OFF_COMMAND_WORD = 8'h1c;
  localparam logic [7:0] OFF_COMMAND_EXTENSION = 8'h20;
  localparam logic [7:0] OFF_INDICATION = 8'h24;

  // ---------------------------------------------------------------
  // primary status register fields
  // ---------------------------------------------------------------
  localparam int SR1_RING_ERROR = 0;
  localparam int SR1_RING_NOT_READY = 1;
  localparam int SR1_HOST_PARITY = 2;
  localparam int SR1_OPERATION_ERROR = 3;
  localparam int SR1_OVERRUN_R4 = 4;
  localparam int SR1_OVERRUN_R5 = 5;
  localparam int SR1_W = 6;

  // ---------------------------------------------------------------
  // internal error register fields
  // ---------------------------------------------------------------
  localparam int IER_RX_TIMEOUT = 0;
  localparam int IER_TX_TIMEOUT = 1;
  localparam int IER_TX_PATH_PAR = 2;
  localparam int IER_MAC_HANDSHAKE = 3;
  localparam int IER_MEM_OVERRUN = 4;
  localparam int IER_PORT_A_PAR = 5;
  localparam int IER_PORT_B_PAR = 6;
  localparam int IER_W = 7;

  // ---------------------------------------------------------------
  // control register fields and reset value
  // ---------------------------------------------------------------
  localparam int CTL_TX_ENABLE = 0;
  localparam int CTL_RX4_ENABLE = 1;
  localparam int CTL_RX5_ENABLE = 2;
  localparam int CTL_HOST_PAR_EN = 3;
  localparam int CTL_RX_ALL = 4;
  localparam int CTL_W = 5;
  localparam logic [4:0] CTL_RESET = 5'h00;

  // function control write bits, mask width (sr1 bits plus one for sr2)
  localparam int FCR_RING_READY = 0;
  localparam int FCR_REDEFINE = 1;
  localparam int IMR_W = 7;

  // port error codes: none, and three that name a parity error
  localparam logic [2:0] PER_NONE = 3'h0;
  localparam logic [2:0] PER_PAR_A = 3'h2;
  localparam logic [2:0] PER_PAR_B = 3'h6;
  localparam logic [2:0] PER_PAR_C = 3'h7;

  typedef enum logic [1:0] {RING_STOPPED, RING_READY, RING_EMPTY} fie_ring_t;

endpackage

// >>> hw/fie_pin_sync.sv
// three-stage synchroniser for pin inputs with second/third stage agreement
`timescale 1ns/1ps
`default_nettype none
module fie_pin_sync #(
  parameter int W = 2
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ---------------------------------------------------------------
  // shift chain; first stage feeds only the second
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once two stages agree, filtering one-cycle glitches
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      level_o <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_o[i] <= s3_q[i];
        end
      end
    end
  end

endmodule // fie_pin_sync
`default_nettype wire

// >>> hw/fie_error_handler.sv
// error handler: flags, ring state, aborts and indications, apb registers
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - rx controller timeout: flag, disable rings, abort
// - tx controller timeout: flag, abort frame, disable
// - tx memory parity: flag, abort frame, disable
// - handshake error: flag, rx abort, resync next
// - memory overrun sets flag until cleared
// - port a/b receive parity flags
// - tx port parity: stop, mark, abort, indicate
// - descriptor parity: stop, discard
// - descriptor parity: ring empty, status bits set
// - status bits cleared by writing ones
// - host write with bad parity ignored
// - bad extension parity discards held command
// - ring parity bit cleared by ready/redefine
// - ring operation bit set, cleared likewise
// - operation error summary sticky until cleared
// - ring overrun bits sticky until cleared
// - ring error set by three causes
// - destination ring error on parity/operation
// - receive error indication on listed causes
// - underrun aborts only current frame
// - mac abort gives abort without others
// - parity codes reported in indications
// - transfer error bit set on port error
module fie_error_handler (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pwpar_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rx_ctrl_timeout_i,
  input wire logic tx_ctrl_timeout_i,
  input wire logic tx_mem_parity_i,
  input wire logic mac_handshake_err_i,
  input wire logic mem_overrun_i,
  input wire logic port_a_rx_par_i,
  input wire logic port_b_rx_par_i,
  input wire logic tx_frame_start_i,
  input wire logic tx_frame_done_i,
  input wire logic tx_port_par_i,
  input wire logic [2:0] tx_per_i,
  input wire logic tx_underrun_i,
  input wire logic transmit_abort_signal_i,
  input wire logic mac_rx_frame_pin_i,
  input wire logic desc_par_i,
  input wire logic port_operation_error_i,
  input wire logic first_last_err_i,
  input wire logic dest_ring_par_i,
  input wire logic dest_ring_poe_i,
  input wire logic ring4_overrun_i,
  input wire logic ring5_overrun_i,
  input wire logic rx_bad_frame_i,
  input wire logic rx_frag_over_wm_i,
  input wire logic xfer_done_i,
  input wire logic [2:0] xfer_per_i,
  output logic receive_abort_signal_o,
  output logic tx_abort_o,
  output logic tx_load_stop_o,
  output logic error_frame_o,
  output logic desc_discard_o,
  output logic rx_resync_wait_o,
  output logic transmit_enable_bit_o,
  output logic ring_four_rx_enable_o,
  output logic ring_five_rx_enable_o,
  output logic cmd_exec_o,
  output logic [31:0] cmd_word_o,
  output logic tx_ind_valid_o,
  output logic [5:0] tx_ind_o,
  output logic xfer_ind_valid_o,
  output logic [3:0] xfer_ind_o,
  output logic rx_err_ind_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [fie_pkg::SR1_W-1:0] primary_status_reg_q;
  logic dest_ring_error_flag_q;
  logic [fie_pkg::IER_W-1:0] internal_error_reg_q;
  logic [fie_pkg::IMR_W-1:0] imr_q;
  logic [fie_pkg::CTL_W-1:0] ctl_q;
  logic ring_par_q;
  logic ring_oer_q;
  fie_pkg::fie_ring_t ring_q;
  logic tx_active_q;
  logic hs_lost_q;
  logic cmd_pend_q;
  logic [1:0] pin_lvl;
  logic mac_abort_q;
  logic mac_frame_q;
  logic acc;
  logic wr;
  logic par_ok;
  logic hwr;
  logic mapped;
  logic tx_abort_ev;
  logic rx_abort_ev;
  logic desc_err;
  logic [fie_pkg::IER_W-1:0] ier_set;
  logic [fie_pkg::SR1_W-1:0] sr1_set;
  logic [31:0] rdata;

  // true when the bus address selects the given register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ---------------------------------------------------------------
  // pin inputs from the mac
  // ---------------------------------------------------------------
  fie_pin_sync #(.W(2)) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .pin_i({mac_rx_frame_pin_i, transmit_abort_signal_i}),
    .level_o(pin_lvl)
  );

  // rising edges of the filtered levels
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mac_abort_q <= 1'b0;
      mac_frame_q <= 1'b0;
    end else begin
      mac_abort_q <= pin_lvl[0];
      mac_frame_q <= pin_lvl[1];
    end
  end

  // ---------------------------------------------------------------
  // apb slave: one wait state, write at the edge pready is seen
  // ---------------------------------------------------------------
  assign acc = psel_i & penable_i & pready_o;
  assign wr = acc & pwrite_i;
  assign par_ok = !ctl_q[fie_pkg::CTL_HOST_PAR_EN] || (^pwdata_i == pwpar_i);
  assign hwr = wr & par_ok;
  assign mapped = hit(paddr_i, fie_pkg::OFF_PRIMARY_STATUS) |
    hit(paddr_i, fie_pkg::OFF_SECONDARY_STATUS) |
    hit(paddr_i, fie_pkg::OFF_INTERNAL_ERROR) |
    hit(paddr_i, fie_pkg::OFF_INT_MASK) |
    hit(paddr_i, fie_pkg::OFF_CONTROL) |
    hit(paddr_i, fie_pkg::OFF_RING_STATE) |
    hit(paddr_i, fie_pkg::OFF_FUNCTION_CONTROL) |
    hit(paddr_i, fie_pkg::OFF_COMMAND_WORD) |
    hit(paddr_i, fie_pkg::OFF_COMMAND_EXTENSION) |
    hit(paddr_i, fie_pkg::OFF_INDICATION);

  // read mux; unmapped and write-only offsets read as zero
  always_comb begin
    rdata = 32'h0;
    unique case (1'b1)
      hit(paddr_i, fie_pkg::OFF_PRIMARY_STATUS):
        rdata[5:0] = primary_status_reg_q;
      hit(paddr_i, fie_pkg::OFF_SECONDARY_STATUS):
        rdata[0] = dest_ring_error_flag_q;
      hit(paddr_i, fie_pkg::OFF_INTERNAL_ERROR):
        rdata[6:0] = internal_error_reg_q;
      hit(paddr_i, fie_pkg::OFF_INT_MASK): rdata[6:0] = imr_q;
      hit(paddr_i, fie_pkg::OFF_CONTROL): rdata[4:0] = ctl_q;
      hit(paddr_i, fie_pkg::OFF_RING_STATE):
        rdata[3:0] = {ring_q, ring_oer_q, ring_par_q};
      hit(paddr_i, fie_pkg::OFF_COMMAND_WORD): rdata = cmd_word_o;
      hit(paddr_i, fie_pkg::OFF_INDICATION):
        rdata[9:0] = {xfer_ind_o, tx_ind_o};
      default: rdata = 32'h0;
    endcase
  end

  // answer a cycle into the access phase; data and error stand with pready
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & penable_i & !pready_o;
      prdata_o <= (psel_i & penable_i & !pready_o & !pwrite_i) ? rdata : 32'h0;
      pslverr_o <= psel_i & penable_i & !pready_o & !mapped;
    end
  end

  // ---------------------------------------------------------------
  // event decode
  // ---------------------------------------------------------------
  assign tx_abort_ev = tx_active_q & (tx_ctrl_timeout_i | tx_mem_parity_i |
    tx_port_par_i | tx_underrun_i | (pin_lvl[0] & !mac_abort_q));
  assign rx_abort_ev = rx_ctrl_timeout_i | mac_handshake_err_i;
  assign desc_err = desc_par_i | port_operation_error_i | first_last_err_i;
  assign ier_set = {port_b_rx_par_i, port_a_rx_par_i, mem_overrun_i,
    mac_handshake_err_i, tx_mem_parity_i, tx_ctrl_timeout_i,
    rx_ctrl_timeout_i};
  assign sr1_set = {ring5_overrun_i, ring4_overrun_i, |ier_set,
    wr & !par_ok, desc_err, desc_err};

  // ---------------------------------------------------------------
  // status registers: write one to clear, a new event wins the clash
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      primary_status_reg_q <= '0;
      dest_ring_error_flag_q <= 1'b0;
      internal_error_reg_q <= '0;
    end else begin
      primary_status_reg_q <= (primary_status_reg_q &
        ~((hwr && hit(paddr_i, fie_pkg::OFF_PRIMARY_STATUS)) ?
        pwdata_i[5:0] : 6'h00)) | sr1_set;
      dest_ring_error_flag_q <= (dest_ring_error_flag_q &
        !(hwr && hit(paddr_i, fie_pkg::OFF_SECONDARY_STATUS) && pwdata_i[0]))
        | dest_ring_par_i | dest_ring_poe_i;
      internal_error_reg_q <= (internal_error_reg_q &
        ~((hwr && hit(paddr_i, fie_pkg::OFF_INTERNAL_ERROR)) ?
        pwdata_i[6:0] : 7'h00)) | ier_set;
    end
  end

  // mask and control; hardware disables override a same-cycle write
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      imr_q <= '0;
      ctl_q <= fie_pkg::CTL_RESET;
    end else begin
      if (hwr && hit(paddr_i, fie_pkg::OFF_INT_MASK)) begin
        imr_q <= pwdata_i[6:0];
      end
      if (hwr && hit(paddr_i, fie_pkg::OFF_CONTROL)) begin
        ctl_q <= pwdata_i[4:0];
      end
      if (tx_ctrl_timeout_i || tx_mem_parity_i) begin
        ctl_q[fie_pkg::CTL_TX_ENABLE] <= 1'b0;
      end
      if (rx_ctrl_timeout_i) begin
        ctl_q[fie_pkg::CTL_RX4_ENABLE] <= 1'b0;
        ctl_q[fie_pkg::CTL_RX5_ENABLE] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // ring state and its error bits
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ring_q <= fie_pkg::RING_STOPPED;
      ring_par_q <= 1'b0;
      ring_oer_q <= 1'b0;
    end else begin
      if (desc_err) begin
        ring_q <= fie_pkg::RING_EMPTY;
      end else if (hwr && hit(paddr_i, fie_pkg::OFF_FUNCTION_CONTROL)) begin
        if (pwdata_i[fie_pkg::FCR_REDEFINE]) begin
          ring_q <= fie_pkg::RING_STOPPED;
        end else if (pwdata_i[fie_pkg::FCR_RING_READY]) begin
          ring_q <= fie_pkg::RING_READY;
        end
      end
      // clear on ready or redefine, but a fresh error still lands
      if (hwr && hit(paddr_i, fie_pkg::OFF_FUNCTION_CONTROL) &&
          |pwdata_i[1:0]) begin
        ring_par_q <= desc_par_i;
        ring_oer_q <= port_operation_error_i | first_last_err_i;
      end else begin
        ring_par_q <= ring_par_q | desc_par_i;
        ring_oer_q <= ring_oer_q | port_operation_error_i |
          first_last_err_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // command word held until the extension register releases it
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cmd_word_o <= 32'h0;
      cmd_pend_q <= 1'b0;
      cmd_exec_o <= 1'b0;
    end else begin
      cmd_exec_o <= 1'b0;
      if (hwr && hit(paddr_i, fie_pkg::OFF_COMMAND_WORD)) begin
        cmd_word_o <= pwdata_i;
        cmd_pend_q <= 1'b1;
      end else if (wr && hit(paddr_i, fie_pkg::OFF_COMMAND_EXTENSION)) begin
        cmd_pend_q <= 1'b0;
        cmd_exec_o <= cmd_pend_q & par_ok;
      end
    end
  end

  // ---------------------------------------------------------------
  // transmit side: frame tracking, abort and indication
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tx_active_q <= 1'b0;
      tx_abort_o <= 1'b0;
      tx_load_stop_o <= 1'b0;
      error_frame_o <= 1'b0;
      tx_ind_valid_o <= 1'b0;
      tx_ind_o <= 6'h00;
    end else begin
      tx_abort_o <= tx_abort_ev;
      tx_load_stop_o <= tx_port_par_i;
      error_frame_o <= tx_port_par_i;
      tx_ind_valid_o <= tx_abort_ev | (tx_active_q & tx_frame_done_i);
      if (tx_abort_ev) begin
        tx_active_q <= 1'b0;
        // {per, pe, un, ab}; mac abort alone leaves un and pe at zero
        tx_ind_o <= {tx_port_par_i ? tx_per_i : fie_pkg::PER_NONE,
          tx_port_par_i | tx_mem_parity_i, tx_underrun_i, 1'b1};
      end else if (tx_active_q && tx_frame_done_i) begin
        tx_active_q <= 1'b0;
        tx_ind_o <= 6'h00;
      end else if (tx_frame_start_i) begin
        tx_active_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // receive side, descriptor reaction, transfer indication, interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      receive_abort_signal_o <= 1'b0;
      hs_lost_q <= 1'b0;
      rx_err_ind_o <= 1'b0;
      desc_discard_o <= 1'b0;
      xfer_ind_valid_o <= 1'b0;
      xfer_ind_o <= 4'h0;
      irq_o <= 1'b0;
    end else begin
      receive_abort_signal_o <= rx_abort_ev;
      // no host help: the next frame from the mac ends the wait
      if (mac_handshake_err_i) begin
        hs_lost_q <= 1'b1;
      end else if (pin_lvl[1] && !mac_frame_q) begin
        hs_lost_q <= 1'b0;
      end
      rx_err_ind_o <= rx_abort_ev | rx_frag_over_wm_i |
        (ctl_q[fie_pkg::CTL_RX_ALL] & rx_bad_frame_i);
      desc_discard_o <= desc_err;
      xfer_ind_valid_o <= xfer_done_i;
      if (xfer_done_i) begin
        xfer_ind_o <= {xfer_per_i, xfer_per_i != fie_pkg::PER_NONE};
      end
      irq_o <= |({dest_ring_error_flag_q, primary_status_reg_q} &
        imr_q);
    end
  end

  assign rx_resync_wait_o = hs_lost_q;
  assign transmit_enable_bit_o = ctl_q[fie_pkg::CTL_TX_ENABLE];
  assign ring_four_rx_enable_o = ctl_q[fie_pkg::CTL_RX4_ENABLE];
  assign ring_five_rx_enable_o = ctl_q[fie_pkg::CTL_RX5_ENABLE];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_desc_fault;
    desc_par_i;
  endsequence
  sequence s_ring_empty;
    ring_q == fie_pkg::RING_EMPTY && ring_par_q &&
      primary_status_reg_q[fie_pkg::SR1_RING_ERROR] &&
      primary_status_reg_q[fie_pkg::SR1_RING_NOT_READY];
  endsequence

  a_rx_timeout_react: assert property (rx_ctrl_timeout_i |=>
    receive_abort_signal_o && !ring_four_rx_enable_o && !ring_five_rx_enable_o)
    else $error("rx timeout reaction missing");
  a_tx_disable: assert property (
    (tx_ctrl_timeout_i || tx_mem_parity_i) |=> !transmit_enable_bit_o)
    else $error("transmit enable not cleared");
  a_tx_abort_ind: assert property (tx_active_q && tx_mem_parity_i |=>
    tx_abort_o && tx_ind_valid_o && tx_ind_o[0] && tx_ind_o[2])
    else $error("tx parity abort missing");
  a_desc_empty: assert property (s_desc_fault |=> s_ring_empty)
    else $error("descriptor fault state wrong");
  a_bad_host_wr: assert property (wr && !par_ok
    && hit(paddr_i, fie_pkg::OFF_INT_MASK) |=> $stable(imr_q))
    else $error("bad parity write took effect");
  a_cer_discard: assert property (wr && !par_ok
    && hit(paddr_i, fie_pkg::OFF_COMMAND_EXTENSION) |=>
    !cmd_exec_o && !cmd_pend_q)
    else $error("bad extension executed command");
  a_ovr_sticky: assert property (
    primary_status_reg_q[fie_pkg::SR1_OVERRUN_R4]
    && !(wr && hit(paddr_i, fie_pkg::OFF_PRIMARY_STATUS)) |=>
    primary_status_reg_q[fie_pkg::SR1_OVERRUN_R4])
    else $error("overrun bit dropped");
  a_mac_abort_ind: assert property (tx_abort_o && !$past(tx_underrun_i)
    && !$past(tx_mem_parity_i) && !$past(tx_port_par_i) |->
    tx_ind_o[2:0] == 3'h1)
    else $error("abort indication wrong");
  a_xfer_err: assert property (
    xfer_done_i && xfer_per_i == fie_pkg::PER_PAR_C
    |=> xfer_ind_valid_o && xfer_ind_o[0])
    else $error("transfer error bit missing");
  a_irq_follow: assert property (|({dest_ring_error_flag_q,
    primary_status_reg_q} & imr_q) |=> irq_o)
    else $error("interrupt not raised");

endmodule // fie_error_handler
`default_nettype wire

// >>> verif/fie_mac_model.sv
// far-side model: mac abort pin and receive frame pin
`timescale 1ns/1ps
`default_nettype none
module fie_mac_model (
  input wire logic clk_i,
  input wire logic abort_req_i,
  input wire logic frame_req_i,
  output logic transmit_abort_signal_pin_o,
  output logic frame_pin_o
);
  logic [2:0] ab_q = '0;
  logic [2:0] fr_q = '0;
  // pins stand low between requests; six cycles outlast the pin sync
  always @(posedge clk_i) begin
    ab_q <= abort_req_i ? 3'h6 : ab_q - 3'(ab_q != 3'h0);
    fr_q <= frame_req_i ? 3'h6 : fr_q - 3'(fr_q != 3'h0);
  end
  assign transmit_abort_signal_pin_o = (ab_q != 3'h0);
  assign frame_pin_o = (fr_q != 3'h0);
endmodule // fie_mac_model
`default_nettype wire

// >>> verif/fie_error_handler_tb.sv
// bench: apb tasks, event pulses and expected flags of the error handler
`timescale 1ns/1ps
`default_nettype none
module fie_error_handler_tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic pwpar_i = 1'b0;
  logic [7:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0;
  logic [31:0] prdata_o;
  logic [31:0] rd;
  logic [31:0] cmd_word_o;
  logic pready_o;
  logic pslverr_o;
  logic err;
  logic clr = 1'b0;
  logic ab_req = 1'b0;
  logic fr_req = 1'b0;
  logic tab_pin;
  logic fr_pin;
  logic [20:0] ev = '0;
  logic [2:0] tx_per_i = '0;
  logic [2:0] xfer_per_i = '0;
  logic [8:0] pul;
  logic [8:0] seen = '0;
  logic [5:0] tx_ind_o;
  logic [5:0] tcap = '0;
  logic [3:0] xfer_ind_o;
  logic [3:0] xcap = '0;
  logic rx_resync_wait_o;
  logic transmit_enable_bit_o;
  logic ring_four_rx_enable_o;
  logic ring_five_rx_enable_o;
  logic irq_o;
  int n_errors = 0;
  int n_compared = 0;
  int n_exec = 0;

  fie_error_handler dut_u (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .pwpar_i, .prdata_o, .pready_o, .pslverr_o,
    .rx_ctrl_timeout_i(ev[0]), .tx_ctrl_timeout_i(ev[1]),
    .tx_mem_parity_i(ev[2]), .mac_handshake_err_i(ev[3]),
    .mem_overrun_i(ev[4]), .port_a_rx_par_i(ev[5]), .port_b_rx_par_i(ev[6]),
    .tx_frame_start_i(ev[7]), .tx_frame_done_i(ev[8]),
    .tx_port_par_i(ev[9]), .tx_per_i, .tx_underrun_i(ev[10]),
    .transmit_abort_signal_i(tab_pin), .mac_rx_frame_pin_i(fr_pin),
    .desc_par_i(ev[11]), .port_operation_error_i(ev[12]),
    .first_last_err_i(ev[13]), .dest_ring_par_i(ev[14]),
    .dest_ring_poe_i(ev[15]), .ring4_overrun_i(ev[16]),
    .ring5_overrun_i(ev[17]), .rx_bad_frame_i(ev[18]),
    .rx_frag_over_wm_i(ev[19]), .xfer_done_i(ev[20]), .xfer_per_i,
    .receive_abort_signal_o(pul[8]), .tx_abort_o(pul[7]),
    .tx_load_stop_o(pul[6]), .error_frame_o(pul[5]),
    .desc_discard_o(pul[4]), .cmd_exec_o(pul[3]), .tx_ind_valid_o(pul[2]),
    .xfer_ind_valid_o(pul[1]), .rx_err_ind_o(pul[0]), .rx_resync_wait_o,
    .transmit_enable_bit_o, .ring_four_rx_enable_o, .ring_five_rx_enable_o,
    .cmd_word_o, .tx_ind_o, .xfer_ind_o, .irq_o);

  fie_mac_model mac_u (.clk_i, .abort_req_i(ab_req), .frame_req_i(fr_req),
    .transmit_abort_signal_pin_o(tab_pin), .frame_pin_o(fr_pin));

  // clock and one-cycle pulse catchers
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    seen <= pul | (clr ? 9'h0 : seen);
    n_exec <= n_exec + int'(pul[3]);
    if (pul[2]) tcap <= tx_ind_o;
    if (pul[1]) xcap <= xfer_ind_o;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; bad flips the write parity on purpose
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic bad);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pwpar_i <= ^d ^ bad;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung transfer
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(nm, e, rd);
  endtask

  // event pulse; the catcher is cleared so only this event's answer shows
  task automatic fire(input int i);
    @(posedge clk_i);
    ev[i] <= 1'b1;
    clr <= 1'b1;
    @(posedge clk_i);
    ev[i] <= 1'b0;
    clr <= 1'b0;
    @(posedge clk_i);
    // results are read at the next edge, before that edge updates them
    @(posedge clk_i);
  endtask

  task automatic conclude;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog well past the length of the sequence
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    conclude();
  end

  // main sequence
  initial begin
    logic [2:0] c;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    rdc("ctl", fie_pkg::OFF_CONTROL, 32'h0);
    apb(1'b0, 8'h40, 32'h0, 1'b0);
    chk("slverr", 32'h1, 32'(err));
    wr(fie_pkg::OFF_CONTROL, 32'h7);
    fire(0);
    chk("rxab", 32'h1, 32'(seen[8]));
    chk("rxen", 32'h0, {ring_five_rx_enable_o, ring_four_rx_enable_o});
    fire(7);
    fire(1);
    chk("txab", 32'h2, {seen[7], transmit_enable_bit_o});
    wr(fie_pkg::OFF_CONTROL, 32'h1);
    fire(7);
    fire(2);
    chk("tpe", 32'h0a, {tcap, transmit_enable_bit_o});
    wr(fie_pkg::OFF_CONTROL, 32'h1);
    fire(7);
    fire(10);
    chk("un", 32'h07, {tcap, transmit_enable_bit_o});
    fire(7);
    @(posedge clk_i);
    ab_req <= 1'b1;
    @(posedge clk_i);
    ab_req <= 1'b0;
    repeat (12) @(posedge clk_i);
    chk("macab", 32'h01, tcap);
    for (int j = 0; j < 3; j++) begin
      c = (j == 0) ? fie_pkg::PER_PAR_A : (j == 1) ? fie_pkg::PER_PAR_B
        : fie_pkg::PER_PAR_C;
      tx_per_i <= c;
      fire(7);
      fire(9);
      chk("tpar", {c, 3'h5}, tcap);
      chk("stop", 32'h3, seen[6:5]);
      xfer_per_i <= (j == 1) ? fie_pkg::PER_NONE : c;
      fire(20);
      chk("xfer", {xfer_per_i, xfer_per_i != 3'h0}, xcap);
    end
    rdc("sr1", fie_pkg::OFF_PRIMARY_STATUS, 32'h08);
    rdc("ier", fie_pkg::OFF_INTERNAL_ERROR, 32'h07);
    wr(fie_pkg::OFF_INTERNAL_ERROR, 32'h7f);
    wr(fie_pkg::OFF_PRIMARY_STATUS, 32'h3f);
    rdc("sr1clr", fie_pkg::OFF_PRIMARY_STATUS, 32'h0);
    for (int j = 4; j < 7; j++) fire(j);
    fire(16);
    fire(17);
    fire(14);
    rdc("ier2", fie_pkg::OFF_INTERNAL_ERROR, 32'h70);
    rdc("ovr", fie_pkg::OFF_PRIMARY_STATUS, 32'h38);
    rdc("dre", fie_pkg::OFF_SECONDARY_STATUS, 32'h1);
    wr(fie_pkg::OFF_INTERNAL_ERROR, 32'h7f);
    wr(fie_pkg::OFF_PRIMARY_STATUS, 32'h3f);
    wr(fie_pkg::OFF_FUNCTION_CONTROL, 32'h1);
    rdc("rdy", fie_pkg::OFF_RING_STATE, 32'h4);
    fire(11);
    chk("disc", 32'h1, 32'(seen[4]));
    rdc("rsr", fie_pkg::OFF_RING_STATE, 32'h9);
    rdc("rer", fie_pkg::OFF_PRIMARY_STATUS, 32'h3);
    wr(fie_pkg::OFF_INT_MASK, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("irq", 32'h1, 32'(irq_o));
    wr(fie_pkg::OFF_PRIMARY_STATUS, 32'h3);
    repeat (2) @(posedge clk_i);
    chk("irq0", 32'h0, 32'(irq_o));
    wr(fie_pkg::OFF_FUNCTION_CONTROL, 32'h1);
    rdc("rdy2", fie_pkg::OFF_RING_STATE, 32'h4);
    fire(13);
    rdc("oer", fie_pkg::OFF_RING_STATE, 32'ha);
    wr(fie_pkg::OFF_FUNCTION_CONTROL, 32'h2);
    apb(1'b0, fie_pkg::OFF_RING_STATE, 32'h0, 1'b0);
    chk("redef", 32'h0, rd[1:0]);
    wr(fie_pkg::OFF_CONTROL, 32'h8);
    apb(1'b1, fie_pkg::OFF_INT_MASK, 32'h3f, 1'b1);
    rdc("hpar", fie_pkg::OFF_INT_MASK, 32'h1);
    rdc("her", fie_pkg::OFF_PRIMARY_STATUS, 32'h7);
    wr(fie_pkg::OFF_COMMAND_WORD, 32'h1234);
    apb(1'b1, fie_pkg::OFF_COMMAND_EXTENSION, 32'h0, 1'b1);
    wr(fie_pkg::OFF_COMMAND_EXTENSION, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("cmd", 32'h0, n_exec);
    wr(fie_pkg::OFF_COMMAND_WORD, 32'h5678);
    wr(fie_pkg::OFF_COMMAND_EXTENSION, 32'h0);
    chk("cmdw", 32'h5678, cmd_word_o);
    repeat (2) @(posedge clk_i);
    chk("cmd1", 32'h1, n_exec);
    fire(3);
    chk("mer", 32'h3, {seen[8], rx_resync_wait_o});
    fr_req <= 1'b1;
    @(posedge clk_i);
    fr_req <= 1'b0;
    repeat (12) @(posedge clk_i);
    chk("resync", 32'h0, 32'(rx_resync_wait_o));
    fire(18);
    chk("rxoff", 32'h0, 32'(seen[0]));
    wr(fie_pkg::OFF_CONTROL, 32'h18);
    fire(18);
    chk("rxerr", 32'h1, 32'(seen[0]));
    fire(19);
    chk("frag", 32'h1, 32'(seen[0]));
    conclude();
  end
endmodule // fie_error_handler_tb
`default_nettype wire
